// file: rtl/cisc_core.sv
// Interrupt entry and return sequencing, configuration guard, stack pointer and flag register.
// Assumes an instruction sequencer on core_clk that reports retires, and up to NSRC
// interrupt sources, each flag or level type, already synchronous to core_clk.
// Overview of operation
// RULE_01: Level sources request only while their condition is present; vanished ones are never taken.
// RULE_02: After handler return, one program instruction retires before another interrupt is served.
// RULE_03: Entry and return never save or restore the flag register.
// RULE_04: Clear-global-enable blocks all service at once, even a request in the same cycle.
// RULE_05: After set-global-enable, the next instruction retires before a pending interrupt is served.
// RULE_06: Entry takes four cycles, pushes the program counter, then jumps to the vector.
// RULE_07: A running multi-cycle instruction completes before entry starts.
// RULE_08: Waking from sleep adds four cycles to entry.
// RULE_09: Return takes four cycles, pops two bytes, adds two to stack pointer, sets enable.
// RULE_10: Unlock value in the key register opens guarded writes for four instructions.
// RULE_11: All interrupts are ignored while the guard window is open; pending ones follow.
// RULE_12: Key register reads bit 0 as window active, bits 7 to 1 as zero.
// RULE_13: Guard covers clock source, clock prescale, and watchdog enable plus prescale bits.
// RULE_14: Stack pointer is 11 bits, stack grows downward, push decrements.
// RULE_15: Flag bit 7 is global enable: cleared on entry, set on return, set/clear ops.
// RULE_16: With global enable low no interrupt is served regardless of source enables.
// RULE_17: Flag bit 6 is the bit holder written by bit-store and read by bit-load.
// RULE_18: Flag bit 4 always equals negative XOR overflow.
// RULE_19: Flag bits 5,3,2,1,0 hold half-carry, overflow, negative, zero, carry from ALU.
// RULE_20: Program counter is 13 bits, addressing 8192 words 0 to 0x1fff.
// RULE_21: Vectoring to a flag source clears its flag; writing one also clears it.
// RULE_22: Lowest-numbered pending enabled source wins; reset outranks all.
// RULE_23: Any other key value leaves guarded registers locked.
`timescale 1ns/1ps
`default_nettype none
`include "cisc_regs.svh"

module cisc_core #(
	parameter int NSRC = 8,
	parameter logic [NSRC-1:0] LEVEL_SRC = '0
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire cisc_pkg::cisc_insn_s insn,
	input wire logic sleeping,
	input wire logic [NSRC-1:0] src_event,
	input wire logic [NSRC-1:0] src_level,
	input wire logic [12:0] pc_now,
	output logic [12:0] program_counter_r,
	output logic pc_load_r,
	output logic seq_stall_r,
	output logic [10:0] sp_addr_r,
	output logic [7:0] sp_wdata_r,
	output logic sp_write_r,
	output logic sp_read_r,
	output logic [7:0] flag_register_r,
	output logic [7:0] clock_source_select_reg_r,
	output logic [7:0] clock_prescale_reg_r,
	output logic [7:0] watchdog_control_reg_r
);
	cisc_pkg::cisc_state_e state_r;
	logic [2:0] cnt_r;
	logic [2:0] guard_cnt_r;
	logic guard_open;
	logic hold_one_r;
	logic [10:0] stack_pointer_r;
	logic [NSRC-1:0] irq_flag_r, irq_en_r;
	logic [NSRC-1:0] pending;
	logic [$clog2(NSRC+1)-1:0] win_idx, sel_idx_r;
	logic win_any;
	logic take;
	logic [15:0] ret_addr_r;
	logic [7:0] pop_lo_r;

	// Bus handshakes
	logic aw_have_r, w_have_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic wr_go;
	logic rd_go;

	assign guard_open = (guard_cnt_r != 3'h0);

	// Flag sources remember events, level sources follow the pin
	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi++) begin : g_src
			assign pending[gi] = irq_en_r[gi] & (LEVEL_SRC[gi] ? src_level[gi] : irq_flag_r[gi]); // [RULE_01]
		end
	endgenerate

	// Priority encoder, lowest index first
	always_comb begin
		win_any = 1'b0;
		win_idx = '0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (pending[i]) begin
				win_any = 1'b1;
				win_idx = i[$clog2(NSRC+1)-1:0]; // [RULE_22]
			end
		end
	end

	// Service gate: global enable, guard, holdoff after set/return, clear-enable in flight
	assign take = (state_r == cisc_pkg::CISC_RUN) && win_any && flag_register_r[`CISC_FLAG_GIE] // [RULE_16]
		&& !guard_open // [RULE_11]
		&& !hold_one_r // [RULE_02] [RULE_05]
		&& !(insn.retire && insn.op_clr_gie) // [RULE_04]
		&& !insn.multi_busy // [RULE_07]
		&& !(insn.retire && (insn.op_return || insn.op_set_gie));

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			hold_one_r <= 1'b0;
		end else if (insn.retire && (insn.op_return || insn.op_set_gie)) begin
			hold_one_r <= 1'b1; // [RULE_02] [RULE_05]
		end else if (insn.retire) begin
			hold_one_r <= 1'b0;
		end
	end

	// Sequencer state
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_r <= cisc_pkg::CISC_RUN;
			cnt_r <= 3'h0;
			sel_idx_r <= '0;
			seq_stall_r <= 1'b0;
		end else begin
			case (state_r)
				cisc_pkg::CISC_RUN: begin
					if (take) begin
						sel_idx_r <= win_idx;
						seq_stall_r <= 1'b1;
						cnt_r <= 3'h1;
						state_r <= sleeping ? cisc_pkg::CISC_WAKE : cisc_pkg::CISC_ENTRY; // [RULE_08]
					end else if (insn.retire && insn.op_return) begin
						seq_stall_r <= 1'b1;
						cnt_r <= 3'h1;
						state_r <= cisc_pkg::CISC_RETURN;
					end
				end
				cisc_pkg::CISC_WAKE: begin
					cnt_r <= cnt_r + 3'h1;
					if (cnt_r == `CISC_WAKE_CYCLES) begin // [RULE_08]
						cnt_r <= 3'h1;
						state_r <= cisc_pkg::CISC_ENTRY;
					end
				end
				cisc_pkg::CISC_ENTRY: begin
					cnt_r <= cnt_r + 3'h1;
					if (cnt_r == `CISC_ENTRY_CYCLES) begin // [RULE_06]
						seq_stall_r <= 1'b0;
						state_r <= cisc_pkg::CISC_RUN;
					end
				end
				cisc_pkg::CISC_RETURN: begin
					cnt_r <= cnt_r + 3'h1;
					if (cnt_r == `CISC_RETURN_CYCLES) begin // [RULE_09]
						seq_stall_r <= 1'b0;
						state_r <= cisc_pkg::CISC_RUN;
					end
				end
				default: begin
					state_r <= cisc_pkg::CISC_RUN;
					seq_stall_r <= 1'b0;
				end
			endcase
		end
	end

	// Stack traffic: two pushes on entry, two pops on return
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			stack_pointer_r <= `CISC_SP_RESET;
			sp_addr_r <= 11'h000;
			sp_wdata_r <= 8'h00;
			sp_write_r <= 1'b0;
			sp_read_r <= 1'b0;
			ret_addr_r <= 16'h0000;
			pop_lo_r <= 8'h00;
		end else begin
			sp_write_r <= 1'b0;
			sp_read_r <= 1'b0;
			if (state_r == cisc_pkg::CISC_RUN && take) begin
				ret_addr_r <= {3'h0, pc_now};
			end
			if (state_r == cisc_pkg::CISC_ENTRY && (cnt_r == 3'h1 || cnt_r == 3'h2)) begin
				sp_addr_r <= stack_pointer_r;
				sp_wdata_r <= (cnt_r == 3'h1) ? ret_addr_r[7:0] : ret_addr_r[15:8];
				sp_write_r <= 1'b1;
				stack_pointer_r <= stack_pointer_r - 11'h001; // [RULE_14]
			end else if (state_r == cisc_pkg::CISC_RETURN && (cnt_r == 3'h1 || cnt_r == 3'h2)) begin
				sp_addr_r <= stack_pointer_r + 11'h001;
				sp_read_r <= 1'b1;
				stack_pointer_r <= stack_pointer_r + 11'h001; // [RULE_09]
			end else if (wr_go && aw_addr_r == `CISC_OFS_SPTR) begin
				if (w_strb_r[0]) stack_pointer_r[7:0] <= w_data_r[7:0];
				if (w_strb_r[1]) stack_pointer_r[10:8] <= w_data_r[10:8];
			end
		end
	end

	// Popped bytes come back on pc_now from the sequencer's data path
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			program_counter_r <= 13'h0000;
			pc_load_r <= 1'b0;
		end else begin
			pc_load_r <= 1'b0;
			if (state_r == cisc_pkg::CISC_ENTRY && cnt_r == `CISC_ENTRY_CYCLES) begin
				program_counter_r <= 13'(({8'h00, sel_idx_r} + 13'h0001) * `CISC_VEC_STEP); // [RULE_06] [RULE_20]
				pc_load_r <= 1'b1;
			end else if (state_r == cisc_pkg::CISC_RETURN && cnt_r == `CISC_RETURN_CYCLES) begin
				program_counter_r <= pc_now & `CISC_PC_LAST; // [RULE_20]
				pc_load_r <= 1'b1;
			end
		end
	end

	// Flag register; entry and return touch only the enable bit
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flag_register_r <= 8'h00;
		end else begin
			if (state_r == cisc_pkg::CISC_RUN && take) begin
				flag_register_r[`CISC_FLAG_GIE] <= 1'b0; // [RULE_15] [RULE_03]
			end else if (state_r == cisc_pkg::CISC_RETURN && cnt_r == `CISC_RETURN_CYCLES) begin
				flag_register_r[`CISC_FLAG_GIE] <= 1'b1; // [RULE_09] [RULE_15]
			end else if (insn.retire && insn.op_clr_gie) begin
				flag_register_r[`CISC_FLAG_GIE] <= 1'b0; // [RULE_04]
			end else if (insn.retire && insn.op_set_gie) begin
				flag_register_r[`CISC_FLAG_GIE] <= 1'b1;
			end else if (wr_go && aw_addr_r == `CISC_OFS_FLAGS && w_strb_r[0]) begin
				flag_register_r <= {w_data_r[7:5], w_data_r[2] ^ w_data_r[3], w_data_r[3:0]}; // [RULE_18]
			end
			if (insn.retire && insn.op_bit_store) begin
				flag_register_r[`CISC_FLAG_T] <= insn.bit_store_val; // [RULE_17]
			end
			if (insn.retire && insn.alu_update) begin
				for (int b = 0; b < 6; b++) begin
					if (insn.alu_mask[b] && b != `CISC_FLAG_S) begin
						flag_register_r[b] <= insn.alu_flags[b]; // [RULE_19]
					end
				end
				flag_register_r[`CISC_FLAG_S] <= (insn.alu_mask[`CISC_FLAG_N] ? insn.alu_flags[`CISC_FLAG_N]
					: flag_register_r[`CISC_FLAG_N]) ^ (insn.alu_mask[`CISC_FLAG_V]
					? insn.alu_flags[`CISC_FLAG_V] : flag_register_r[`CISC_FLAG_V]); // [RULE_18]
			end
		end
	end

	// Guard window counts retired instructions after the unlock write
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			guard_cnt_r <= 3'h0;
		end else if (wr_go && aw_addr_r == `CISC_OFS_KEY && w_strb_r[0]
			&& w_data_r[7:0] == `CISC_UNLOCK_KEY) begin // [RULE_23]
			guard_cnt_r <= `CISC_GUARD_INSNS; // [RULE_10]
		end else if (guard_open && insn.retire) begin
			guard_cnt_r <= guard_cnt_r - 3'h1;
		end
	end

	// Guarded registers; a locked write to a guarded field is dropped silently
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			clock_source_select_reg_r <= 8'h00;
			clock_prescale_reg_r <= 8'h00;
			watchdog_control_reg_r <= 8'h00;
		end else if (wr_go && w_strb_r[0]) begin
			if (aw_addr_r == `CISC_OFS_CLKSRC && guard_open) begin
				clock_source_select_reg_r <= w_data_r[7:0]; // [RULE_13] [RULE_23]
			end
			if (aw_addr_r == `CISC_OFS_CLKPRE && guard_open) begin
				clock_prescale_reg_r <= w_data_r[7:0]; // [RULE_13]
			end
			if (aw_addr_r == `CISC_OFS_WDOG) begin
				watchdog_control_reg_r <= guard_open ? w_data_r[7:0]
					: ((watchdog_control_reg_r & `CISC_WDOG_GUARD_MASK)
					| (w_data_r[7:0] & ~`CISC_WDOG_GUARD_MASK)); // [RULE_13]
			end
		end
	end

	// Source flags: set wins over a same-cycle clear
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq_flag_r <= '0;
			irq_en_r <= '0;
		end else begin
			for (int i = 0; i < NSRC; i++) begin
				if (src_event[i] && !LEVEL_SRC[i]) begin
					irq_flag_r[i] <= 1'b1;
				end else if (take && win_idx == i[$clog2(NSRC+1)-1:0]) begin
					irq_flag_r[i] <= 1'b0; // [RULE_21]
				end else if (wr_go && aw_addr_r == `CISC_OFS_IRQ_FLAG && w_data_r[i]) begin
					irq_flag_r[i] <= 1'b0; // [RULE_21]
				end
			end
			if (wr_go && aw_addr_r == `CISC_OFS_IRQ_EN) begin
				irq_en_r <= w_data_r[NSRC-1:0];
			end
		end
	end

	// AXI4-Lite write channel: address and data in either order
	assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			s_axi_awready <= !aw_have_r && !s_axi_awready;
			s_axi_wready <= !w_have_r && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_r > `CISC_OFS_STATUS || aw_addr_r[1:0] != 2'h0) ? 2'h2 : 2'h0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel
	assign rd_go = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (rd_go) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case (s_axi_araddr)
					`CISC_OFS_KEY: s_axi_rdata <= {31'h0, guard_open}; // [RULE_12]
					`CISC_OFS_SPTR: s_axi_rdata <= {21'h0, stack_pointer_r};
					`CISC_OFS_FLAGS: s_axi_rdata <= {24'h0, flag_register_r};
					`CISC_OFS_CLKSRC: s_axi_rdata <= {24'h0, clock_source_select_reg_r};
					`CISC_OFS_CLKPRE: s_axi_rdata <= {24'h0, clock_prescale_reg_r};
					`CISC_OFS_WDOG: s_axi_rdata <= {24'h0, watchdog_control_reg_r};
					`CISC_OFS_IRQ_FLAG: s_axi_rdata <= 32'(irq_flag_r);
					`CISC_OFS_IRQ_EN: s_axi_rdata <= 32'(irq_en_r);
					`CISC_OFS_STATUS: s_axi_rdata <= {26'h0, hold_one_r, guard_open, seq_stall_r, state_r};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= 2'h2;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

// file: rtl/cisc_pkg.sv
// Types shared by the interrupt and status sequencer.
// Assumes the constants header is compiled alongside.
package cisc_pkg;
	typedef enum logic [2:0] {
		CISC_RUN = 3'h0,
		CISC_WAKE = 3'h1,
		CISC_ENTRY = 3'h3,
		CISC_RETURN = 3'h2
	} cisc_state_e;

	// One retired instruction from the sequencer
	typedef struct packed {
		logic retire;
		logic multi_busy;
		logic op_set_gie;
		logic op_clr_gie;
		logic op_return;
		logic op_bit_store;
		logic bit_store_val;
		logic alu_update;
		logic [5:0] alu_flags;
		logic [5:0] alu_mask;
	} cisc_insn_s;
endpackage

// file: rtl/cisc_regs.svh
// Register offsets, field positions, reset values and cycle counts for the interrupt sequencer.
// Assumes a 32-bit AXI4-Lite register port with one register per aligned word.
`ifndef CISC_REGS_SVH
`define CISC_REGS_SVH

`define CISC_OFS_KEY 8'h00
`define CISC_OFS_SPTR 8'h04
`define CISC_OFS_FLAGS 8'h08
`define CISC_OFS_CLKSRC 8'h0c
`define CISC_OFS_CLKPRE 8'h10
`define CISC_OFS_WDOG 8'h14
`define CISC_OFS_IRQ_FLAG 8'h18
`define CISC_OFS_IRQ_EN 8'h1c
`define CISC_OFS_STATUS 8'h20

`define CISC_UNLOCK_KEY 8'hd8
`define CISC_GUARD_INSNS 3'h4
`define CISC_ENTRY_CYCLES 3'h4
`define CISC_WAKE_CYCLES 3'h4
`define CISC_RETURN_CYCLES 3'h4

`define CISC_FLAG_GIE 7
`define CISC_FLAG_T 6
`define CISC_FLAG_H 5
`define CISC_FLAG_S 4
`define CISC_FLAG_V 3
`define CISC_FLAG_N 2
`define CISC_FLAG_Z 1
`define CISC_FLAG_C 0

`define CISC_WDOG_GUARD_MASK 8'h2f
`define CISC_SP_RESET 11'h4ff
`define CISC_PC_LAST 13'h1fff
`define CISC_VEC_STEP 13'h0002

`endif

// file: testbench/cisc_core_asserts.sv
// Port checker for cisc_core: stack, entry, return and flag timing.
// Assumes one clock domain; bound to every cisc_core instance.
`timescale 1ns/1ps
`default_nettype none
`include "cisc_regs.svh"
module cisc_core_asserts (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire cisc_pkg::cisc_insn_s insn,
	input wire logic pc_load_r,
	input wire logic seq_stall_r,
	input wire logic [10:0] sp_addr_r,
	input wire logic sp_write_r,
	input wire logic sp_read_r,
	input wire logic [7:0] flag_register_r
);
	logic key_rd_r;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// Remember which register the pending read targets
	always_ff @(posedge core_clk) begin
		if (s_axi_arvalid && s_axi_arready) begin
			key_rd_r <= (s_axi_araddr == `CISC_OFS_KEY);
		end
	end
	sequence push_q;
		sp_write_r ##1 sp_write_r;
	endsequence
	sequence pop_q;
		sp_read_r ##1 sp_read_r;
	endsequence
	sign_flag_a: assert property (flag_register_r[4] == (flag_register_r[2] ^ flag_register_r[3]))
		else $error("sign flag is not n xor v");
	push_down_a: assert property (push_q |-> sp_addr_r == $past(sp_addr_r) - 11'h1)
		else $error("push did not step down");
	pop_up_a: assert property (pop_q |-> sp_addr_r == $past(sp_addr_r) + 11'h1)
		else $error("pop did not step up");
	entry_push_a: assert property ($rose(sp_write_r) |-> push_q ##1 !sp_write_r ##[0:6] pc_load_r)
		else $error("entry push or vector load wrong");
	entry_gie_a: assert property ($rose(sp_write_r) |-> !flag_register_r[7] && seq_stall_r)
		else $error("enable not cleared on entry");
	return_a: assert property ($rose(sp_read_r) |-> pop_q ##[0:3] (pc_load_r ##[0:1] flag_register_r[7]))
		else $error("return did not load and enable");
	multi_wait_a: assert property ($rose(seq_stall_r) |-> !$past(insn.multi_busy))
		else $error("entry during multi-cycle op");
	clr_block_a: assert property ($rose(seq_stall_r) |-> !($past(insn.retire) && $past(insn.op_clr_gie)))
		else $error("entry after clear enable");
	gie_gate_a: assert property ($rose(seq_stall_r) && !$past(insn.op_return) |-> $past(flag_register_r[7]))
		else $error("entry with enable low");
	key_read_a: assert property (s_axi_rvalid && key_rd_r |-> s_axi_rdata[31:1] == 31'h0)
		else $error("key upper bits not zero");
endmodule
bind cisc_core cisc_core_asserts cisc_core_asserts_inst (.core_clk, .sys_rst, .s_axi_arvalid, .s_axi_arready,
	.s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .insn, .pc_load_r, .seq_stall_r, .sp_addr_r, .sp_write_r,
	.sp_read_r, .flag_register_r);
`default_nettype wire

// file: testbench/cisc_seq_model.sv
// Sequencer stand-in: retires commanded instructions and pulses source events.
// Assumes the core's stall and program counter load outputs on core_clk.
`timescale 1ns/1ps
`default_nettype none
module cisc_seq_model (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic go,
	input wire cisc_pkg::cisc_insn_s op,
	input wire logic [7:0] ev,
	input wire logic [3:0] len,
	input wire logic seq_stall_r,
	input wire logic pc_load_r,
	input wire logic [12:0] program_counter_r,
	input wire logic [10:0] sp_addr_r,
	input wire logic [7:0] sp_wdata_r,
	input wire logic sp_write_r,
	input wire logic sp_read_r,
	output var cisc_pkg::cisc_insn_s insn,
	output logic [7:0] src_event,
	output logic [12:0] pc_now,
	output logic busy
);
	logic [3:0] cnt_r;
	logic [7:0] ev_r;
	logic [7:0] stk_r [0:2047];
	logic [7:0] pop_hi_r;
	// Events leave on the first busy cycle, so a single-cycle op retires alongside them
	always_ff @(posedge core_clk) begin
		insn <= '0;
		src_event <= ev_r;
		ev_r <= '0;
		if (sys_rst) begin
			busy <= 1'b0;
			cnt_r <= '0;
		end else if (go) begin
			busy <= 1'b1;
			cnt_r <= len;
			ev_r <= ev;
		end else if (busy && cnt_r != 4'h0) begin
			insn.multi_busy <= 1'b1;
			cnt_r <= cnt_r - 4'h1;
		end else if (busy && (!seq_stall_r || !op.retire)) begin
			insn <= op;
			busy <= 1'b0;
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pc_now <= '0;
		end else if (pc_load_r) begin
			pc_now <= program_counter_r;
		end else if (sp_read_r) begin
			pc_now <= 13'({pop_hi_r, stk_r[sp_addr_r]});
		end else if (insn.retire) begin
			pc_now <= pc_now + 13'h1;
		end
	end
	// Stack memory; pops come back high byte first, so the second pop completes pc_now
	always_ff @(posedge core_clk) begin
		if (sp_write_r) begin
			stk_r[sp_addr_r] <= sp_wdata_r;
		end
		if (sys_rst) begin
			pop_hi_r <= 8'h00;
		end else if (sp_read_r) begin
			pop_hi_r <= stk_r[sp_addr_r];
		end
	end
endmodule
`default_nettype wire

// file: testbench/cpu_interrupt_status_control_tb.sv
// Bench for cisc_core: registers over AXI4-Lite, instructions through the sequencer model.
// Assumes the package and constants header are compiled first; one 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "cisc_regs.svh"
module cpu_interrupt_status_control_tb;
	logic core_clk = 1'b0, sys_rst = 1'b1, sleeping = 1'b0, go = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, src_level = '0, ev = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf, len = '0;
	cisc_pkg::cisc_insn_s op = '0, insn, xop = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pc_load_r, seq_stall_r, busy;
	logic sp_write_r, sp_read_r;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic [7:0] src_event, flag_register_r, clock_source_select_reg_r, clock_prescale_reg_r, sp_wdata_r;
	logic [7:0] watchdog_control_reg_r;
	logic [12:0] pc_now, program_counter_r, ret_pc;
	logic [10:0] sp_addr_r;
	int mismatches = 0, num_checks = 0, n0, n1;
	cisc_core #(.NSRC(8), .LEVEL_SRC(8'h80)) cisc_core_inst (.*);
	cisc_seq_model cisc_seq_model_inst (.*);
	always #4 core_clk = ~core_clk;
	// Return address as pushed on entry, for comparison with the popped one
	always @(posedge core_clk) if (sp_write_r === 1'b1) ret_pc <= pc_now;
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic lim(input int i);
		if (i >= 200) begin
			mismatches++;
			conclude();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int i;
		i = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			i++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && i < 200);
		s_axi_bready <= 1'b0;
		rr = s_axi_bresp;
		lim(i);
	endtask
	task automatic rd(input logic [7:0] a);
		int i;
		i = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			i++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && i < 200);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		rr = s_axi_rresp;
		lim(i);
	endtask
	task automatic run(input logic q, s, c, r, input logic [7:0] e, input logic [3:0] n);
		int i;
		cisc_pkg::cisc_insn_s o;
		i = 0;
		o = xop;
		o.retire = q;
		o.op_set_gie = s;
		o.op_clr_gie = c;
		o.op_return = r;
		op <= o;
		ev <= e;
		len <= n;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		do begin
			@(posedge core_clk);
			i++;
		end while (busy !== 1'b0 && i < 200);
		lim(i);
	endtask
	task automatic step;
		run(1'b1, 1'b0, 1'b0, 1'b0, 8'h0, 4'h0);
	endtask
	// Counts stall cycles up to the vector or return load, then lets the flags settle
	task automatic wpc(output int n);
		int i;
		i = 0;
		n = 0;
		do begin
			@(posedge core_clk);
			i++;
			if (seq_stall_r === 1'b1) n++;
		end while (pc_load_r !== 1'b1 && i < 200);
		lim(i);
		@(posedge core_clk);
	endtask
	task automatic quiet(input string nm);
		int k;
		k = 0;
		repeat (16) begin
			@(posedge core_clk);
			if (seq_stall_r !== 1'b0) k++;
		end
		chk(nm, k, 0);
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(`CISC_OFS_SPTR);
		chk("sp", d, 32'h4ff);
		rd(8'h40);
		chk("unmapped", rr, 32'h2);
		wr(8'h40, 32'h0);
		chk("bresp unmapped", rr, 32'h2);
		wr(`CISC_OFS_KEY, 32'h55);
		chk("bresp", rr, 32'h0);
		wr(`CISC_OFS_CLKSRC, 32'h5a);
		wr(`CISC_OFS_WDOG, 32'hff);
		chk("clksrc", clock_source_select_reg_r, 32'h0);
		chk("wdog", watchdog_control_reg_r, 32'hd0);
		wr(`CISC_OFS_KEY, 32'hd8);
		rd(`CISC_OFS_KEY);
		chk("key", d, 32'h1);
		wr(`CISC_OFS_CLKPRE, 32'h33);
		wr(`CISC_OFS_WDOG, 32'hff);
		chk("clkpre", clock_prescale_reg_r, 32'h33);
		chk("wdog", watchdog_control_reg_r, 32'hff);
		repeat (4) step();
		rd(`CISC_OFS_KEY);
		chk("key", d, 32'h0);
		$display("test guard done");
		wr(`CISC_OFS_IRQ_EN, 32'h86);
		wr(`CISC_OFS_FLAGS, 32'h21);
		run(1'b1, 1'b1, 1'b0, 1'b0, 8'h04, 4'h0);
		quiet("sei");
		run(1'b1, 1'b0, 1'b0, 1'b0, 8'h0, 4'h2);
		wpc(n0);
		chk("vector", program_counter_r, 32'h6);
		chk("flags", flag_register_r, 32'h21);
		rd(`CISC_OFS_SPTR);
		chk("sp", d, 32'h4fd);
		rd(`CISC_OFS_IRQ_FLAG);
		chk("irq flag", d, 32'h0);
		run(1'b0, 1'b0, 1'b0, 1'b0, 8'h22, 4'h0);
		quiet("gie low");
		run(1'b1, 1'b0, 1'b0, 1'b1, 8'h0, 4'h0);
		wpc(n1);
		chk("flags", flag_register_r, 32'ha1);
		chk("return pc", program_counter_r, ret_pc);
		rd(`CISC_OFS_SPTR);
		chk("sp", d, 32'h4ff);
		quiet("handler_return_op");
		step();
		wpc(n1);
		chk("vector", program_counter_r, 32'h4);
		rd(`CISC_OFS_IRQ_FLAG);
		chk("irq flag", d, 32'h20);
		wr(`CISC_OFS_IRQ_FLAG, 32'h20);
		rd(`CISC_OFS_IRQ_FLAG);
		chk("irq flag", d, 32'h0);
		$display("test entry done");
		run(1'b1, 1'b0, 1'b0, 1'b1, 8'h0, 4'h0);
		wpc(n1);
		chk("return pc", program_counter_r, ret_pc);
		step();
		run(1'b1, 1'b0, 1'b1, 1'b0, 8'h02, 4'h0);
		quiet("cli");
		chk("gie", flag_register_r[7], 32'h0);
		wr(`CISC_OFS_IRQ_FLAG, 32'h02);
		src_level <= 8'h80;
		run(1'b0, 1'b0, 1'b0, 1'b0, 8'h0, 4'h0);
		src_level <= 8'h00;
		run(1'b1, 1'b1, 1'b0, 1'b0, 8'h0, 4'h0);
		step();
		quiet("level gone");
		sleeping <= 1'b1;
		src_level <= 8'h80;
		wpc(n1);
		chk("vector", program_counter_r, 32'h10);
		chk("wake", n1, n0 + 4);
		sleeping <= 1'b0;
		src_level <= 8'h00;
		$display("test level done");
		run(1'b1, 1'b0, 1'b0, 1'b1, 8'h0, 4'h0);
		wpc(n1);
		step();
		wr(`CISC_OFS_KEY, 32'hd8);
		run(1'b1, 1'b0, 1'b0, 1'b0, 8'h02, 4'h0);
		repeat (2) step();
		quiet("window");
		step();
		wpc(n1);
		chk("vector", program_counter_r, 32'h4);
		$display("test window done");
		xop.op_bit_store = 1'b1;
		xop.bit_store_val = 1'b1;
		xop.alu_update = 1'b1;
		xop.alu_flags = 6'h06;
		xop.alu_mask = 6'h07;
		step();
		xop = '0;
		@(posedge core_clk);
		chk("alu flags", flag_register_r, 32'h76);
		$display("test flags done");
		conclude();
	end
endmodule
`default_nettype wire
